/* rtl/sarl_top.sv */
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// [R1] Sector-architecture bit 0 selects hybrid and 1 uniform; nonvolatile copy is writable, volatile copy read-only.
// [R2] In hybrid layout the small-sector block is mapped at the top, bottom or both ends per split and top/bottom bits.
// [R3] In uniform layout the small-sector block is removed so all sectors are large.
// [R4] Small-sector erase opcode 20h is executed only in hybrid layout and ignored in uniform layout.
// [R5] The host always writes reserved bits 2 to 0 of both copies as zero.
// [R6] SPI register reads take 0/1/1/2 dummies for argument and dynamic-protect, 0/0/1/2 for the others.
// [R7] Octal SDR register reads take 3, 4, 5 or 6 dummies for codes 00 to 11.
// [R8] Octal DDR register reads take 3, 4, 5 or 6 dummies for codes 00 to 11.
// [R9] Unique-identifier reads always take 32 dummies.
// [R10] The octal CRC read always takes 8 dummies.
// [R11] Argument reads of a volatile register use the latency-code dummies.
// [R12] The host picks a latency code whose rated frequency covers its clock.
// [R13] The host keeps the SPI SDR clock at or below 166 MHz.
// [R14] Bits 7:6 of the configuration register select the dummies of all variable-latency register reads.
// [R15] The volatile copy is loaded from the nonvolatile copy at reset and steers the behaviour; code resets it to CFG_RESET, copying only on reload.
module sarl_top #(
    parameter logic [5:0] NV_ARG_DUMMY = 6'h08
) (
    // Bus clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Address map
    output logic                   small_sector_low_en,
    output logic                   small_sector_high_en,
    // Link side
    input  wire logic              link_clk,
    input  wire logic              cmd_valid,
    input  wire sarl_pkg::sarl_cmd_s cmd,
    output logic                   dummy_valid,
    output logic [5:0]             dummy_cycles,
    output logic                   erase_start
);
    logic        aw_held, w_held, wstrb0;
    logic [7:0]  aw_q, wd_q;
    logic        wr_go, wr_nv, wr_vol, wr_sec, wr_ctl, wr_st;
    logic [7:0]  config_three_nonvolatile, config_three_volatile;
    logic        small_sector_split_select, small_sector_top_bottom_select;
    logic        ign_flag, acc_flag;
    logic [31:0] next_rdata;
    logic        hybrid;

    // Shared decode for both address channels
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == sarl_pkg::ADDR_NV) || (a == sarl_pkg::ADDR_VOL) || (a == sarl_pkg::ADDR_SECTOR) ||
                  (a == sarl_pkg::ADDR_CTRL) || (a == sarl_pkg::ADDR_STATUS);
    endfunction : addr_ok

    // Channels are held until both are present, so either order works
    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;
    assign wr_go   = aw_held && w_held && !bvalid;
    assign wr_nv   = wr_go && wstrb0 && (aw_q == sarl_pkg::ADDR_NV);
    assign wr_vol  = wr_go && wstrb0 && (aw_q == sarl_pkg::ADDR_VOL);
    assign wr_sec  = wr_go && wstrb0 && (aw_q == sarl_pkg::ADDR_SECTOR);
    assign wr_ctl  = wr_go && wstrb0 && (aw_q == sarl_pkg::ADDR_CTRL);
    assign wr_st   = wr_go && wstrb0 && (aw_q == sarl_pkg::ADDR_STATUS);

    // Write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_q    <= 8'h00;
            wd_q    <= 8'h00;
            wstrb0  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_q    <= awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wd_q   <= wdata[7:0];
                wstrb0 <= wstrb[0];
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= sarl_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= addr_ok(aw_q) ? sarl_pkg::RESP_OKAY : sarl_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Nonvolatile copy takes reserved bits as written; keeping them zero is software's duty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_three_nonvolatile <= sarl_pkg::CFG_RESET;
        end else if (wr_nv) begin
            config_three_nonvolatile <= wd_q; // R1 R5
        end
    end

    // Volatile copy: reloaded from nonvolatile, architecture bit not writable here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_three_volatile <= sarl_pkg::CFG_RESET; // R15
        end else if (wr_ctl && wd_q[sarl_pkg::RELOAD_BIT]) begin
            config_three_volatile <= config_three_nonvolatile; // R15
        end else if (wr_vol) begin
            config_three_volatile <= (config_three_volatile & ~sarl_pkg::VOL_WR_MASK) |
                                     (wd_q & sarl_pkg::VOL_WR_MASK); // R1
        end
    end

    // Small-sector placement bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            small_sector_split_select      <= 1'b0;
            small_sector_top_bottom_select <= 1'b0;
        end else if (wr_sec) begin
            small_sector_split_select      <= wd_q[sarl_pkg::SPLIT_BIT];
            small_sector_top_bottom_select <= wd_q[sarl_pkg::TOPBOT_BIT];
        end
    end

    // Map decode from the volatile copy: split puts halves at both ends
    assign hybrid = config_three_volatile[sarl_pkg::ARCH_BIT] == sarl_pkg::ARCH_HYBRID; // R1 R15
    // Map outputs come from flops; reset value matches the hybrid, top placement default
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            small_sector_high_en <= 1'b1;
            small_sector_low_en  <= 1'b0;
        end else begin
            small_sector_high_en <= hybrid && (small_sector_split_select || !small_sector_top_bottom_select); // R2 R3
            small_sector_low_en  <= hybrid && (small_sector_split_select || small_sector_top_bottom_select); // R2 R3
        end
    end

    // Configuration handoff to link domain by toggle handshake
    sarl_pkg::sarl_cfg_s cfg_word, cfg_hold, link_cfg;
    logic        req_tgl, ack_m, ack_s, req_m, req_s, req_seen;
    logic        ign_tgl, acc_tgl, ign_m, ign_s, ign_d, acc_m, acc_s, acc_d;
    logic        lrst_m, link_rst_n;
    assign cfg_word = '{lat:  config_three_volatile[sarl_pkg::LAT_HI:sarl_pkg::LAT_LO],
                        arch: config_three_volatile[sarl_pkg::ARCH_BIT]}; // R14

    // Held word stays stable until the link side has acknowledged it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_hold <= '0;
            req_tgl  <= 1'b0;
        end else if ((req_tgl == ack_s) && (cfg_word != cfg_hold)) begin
            cfg_hold <= cfg_word;
            req_tgl  <= ~req_tgl;
        end
    end

    // Synchronisers into the bus domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {ack_m, ack_s, ign_m, ign_s, ign_d, acc_m, acc_s, acc_d} <= 8'h00;
        end else begin
            ack_m <= req_seen;
            ack_s <= ack_m;
            ign_m <= ign_tgl;
            ign_s <= ign_m;
            ign_d <= ign_s;
            acc_m <= acc_tgl;
            acc_s <= acc_m;
            acc_d <= acc_s;
        end
    end

    // Sticky erase flags, write one to clear; a new event wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ign_flag <= 1'b0;
            acc_flag <= 1'b0;
        end else begin
            ign_flag <= (ign_s ^ ign_d) | (ign_flag & ~(wr_st & wd_q[sarl_pkg::ST_IGNORED]));
            acc_flag <= (acc_s ^ acc_d) | (acc_flag & ~(wr_st & wd_q[sarl_pkg::ST_ACCEPTED]));
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (araddr)
            sarl_pkg::ADDR_NV:     next_rdata[7:0] = config_three_nonvolatile;
            sarl_pkg::ADDR_VOL:    next_rdata[7:0] = config_three_volatile;
            sarl_pkg::ADDR_SECTOR: next_rdata[1:0] = {small_sector_top_bottom_select, small_sector_split_select};
            sarl_pkg::ADDR_STATUS: next_rdata[2:0] = {acc_flag, ign_flag, hybrid};
            default:               next_rdata = 32'h0000_0000;
        endcase
    end

    // Read response one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= sarl_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= next_rdata;
            rresp  <= addr_ok(araddr) ? sarl_pkg::RESP_OKAY : sarl_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Link reset derived from bus reset; needs a few link edges to take hold
    always_ff @(posedge link_clk) begin
        lrst_m     <= aresetn;
        link_rst_n <= lrst_m;
    end

    // Link-side capture of the configuration word
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            {req_m, req_s, req_seen} <= 3'h0;
            link_cfg <= '0;
        end else begin
            req_m <= req_tgl;
            req_s <= req_m;
            if (req_s != req_seen) begin
                req_seen <= req_s;
                link_cfg <= cfg_hold;
            end
        end
    end

    // Dummy cycle lookup by mode, command class and latency code
    function automatic logic [5:0] dummy_for(input sarl_pkg::sarl_cmd_s c, input logic [1:0] lat);
        logic [7:0] tbl;
        tbl = (c.cls == sarl_pkg::CLS_ARG || c.cls == sarl_pkg::CLS_DYB) ? sarl_pkg::SPI_ARG_TABLE
                                                                          : sarl_pkg::SPI_REG_TABLE;
        if (c.cls == sarl_pkg::CLS_UID) begin
            dummy_for = sarl_pkg::UID_DUMMY; // R9
        end else if (c.cls == sarl_pkg::CLS_CRC) begin
            dummy_for = sarl_pkg::CRC_DUMMY; // R10
        end else if (c.cls == sarl_pkg::CLS_OTHER) begin
            dummy_for = 6'h00;
        end else if (c.cls == sarl_pkg::CLS_ARG && !c.vol_target) begin
            dummy_for = NV_ARG_DUMMY; // R11
        end else if (c.mode == sarl_pkg::MODE_SPI) begin
            dummy_for = {4'h0, tbl[{lat, 1'b0} +: 2]}; // R6 R14
        end else begin
            dummy_for = sarl_pkg::OCT_BASE + {4'h0, lat}; // R7 R8 R14
        end
    endfunction : dummy_for

    // Per-command answer, one link cycle after the command
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            dummy_valid  <= 1'b0;
            dummy_cycles <= 6'h00;
            erase_start  <= 1'b0;
            ign_tgl      <= 1'b0;
            acc_tgl      <= 1'b0;
        end else begin
            dummy_valid <= cmd_valid && (cmd.cls != sarl_pkg::CLS_OTHER);
            erase_start <= 1'b0;
            if (cmd_valid) begin
                dummy_cycles <= dummy_for(cmd, link_cfg.lat);
            end
            if (cmd_valid && cmd.opcode == sarl_pkg::OPC_SMALL_ERASE) begin
                if (link_cfg.arch == sarl_pkg::ARCH_HYBRID) begin
                    erase_start <= 1'b1; // R4
                    acc_tgl     <= ~acc_tgl;
                end else begin
                    ign_tgl <= ~ign_tgl; // R4
                end
            end
        end
    end

    AST_VOL_ARCH_KEPT: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        wr_vol |=> config_three_volatile[sarl_pkg::ARCH_BIT] == $past(config_three_volatile[sarl_pkg::ARCH_BIT]))
        else $error("volatile architecture bit changed by a write");
    AST_MAP_HYBRID: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        hybrid |=> (small_sector_low_en || small_sector_high_en) &&
                   ((small_sector_low_en && small_sector_high_en) == $past(small_sector_split_select)))
        else $error("hybrid layout map wrong");
    AST_MAP_UNIFORM: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        !hybrid |=> !small_sector_low_en && !small_sector_high_en)
        else $error("small-sector block mapped in uniform layout");
    AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        (wr_ctl && wd_q[sarl_pkg::RELOAD_BIT]) |=> config_three_volatile == $past(config_three_nonvolatile))
        else $error("volatile copy not reloaded");
    AST_ERASE_HYBRID: assert property (@(posedge link_clk) disable iff (!link_rst_n) // R4
        (cmd_valid && cmd.opcode == sarl_pkg::OPC_SMALL_ERASE) |=> erase_start == $past(link_cfg.arch == 1'b0))
        else $error("small-sector erase handled against layout");
    AST_UID: assert property (@(posedge link_clk) disable iff (!link_rst_n) // R9
        (cmd_valid && cmd.cls == sarl_pkg::CLS_UID) |=> dummy_valid && dummy_cycles == 6'd32)
        else $error("unique id read without 32 dummies");
    AST_CRC: assert property (@(posedge link_clk) disable iff (!link_rst_n) // R10
        (cmd_valid && cmd.cls == sarl_pkg::CLS_CRC) |=> dummy_cycles == 6'd8)
        else $error("crc read without 8 dummies");
    AST_OCTAL: assert property (@(posedge link_clk) disable iff (!link_rst_n) // R7
        (cmd_valid && cmd.mode != sarl_pkg::MODE_SPI && cmd.cls == sarl_pkg::CLS_STATUS)
        |=> dummy_cycles == 6'd3 + {4'h0, $past(link_cfg.lat)})
        else $error("octal register read dummies wrong");
    AST_SPI_ARG_TOP: assert property (@(posedge link_clk) disable iff (!link_rst_n) // R6
        (cmd_valid && cmd.mode == sarl_pkg::MODE_SPI && cmd.cls == sarl_pkg::CLS_DYB && link_cfg.lat == 2'b11)
        |=> dummy_cycles == 6'd2)
        else $error("spi dynamic protect read dummies wrong");
    AST_SPI_REG_LOW: assert property (@(posedge link_clk) disable iff (!link_rst_n) // R6
        (cmd_valid && cmd.mode == sarl_pkg::MODE_SPI && cmd.cls == sarl_pkg::CLS_IDENT && link_cfg.lat == 2'b01)
        |=> dummy_cycles == 6'd0)
        else $error("spi ident read dummies wrong");
endmodule : sarl_top

/* rtl/sarl_pkg.sv */
package sarl_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_NV       = 8'h00;
    localparam logic [7:0] ADDR_VOL      = 8'h04;
    localparam logic [7:0] ADDR_SECTOR   = 8'h08;
    localparam logic [7:0] ADDR_CTRL     = 8'h0C;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    // Field positions
    localparam int         LAT_HI        = 7;
    localparam int         LAT_LO        = 6;
    localparam int         ARCH_BIT      = 3;
    localparam int         SPLIT_BIT     = 0;
    localparam int         TOPBOT_BIT    = 1;
    localparam int         RELOAD_BIT    = 0;
    localparam int         ST_HYBRID     = 0;
    localparam int         ST_IGNORED    = 1;
    localparam int         ST_ACCEPTED   = 2;
    // Reset values and masks
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] VOL_WR_MASK   = 8'hC7;
    localparam logic       ARCH_HYBRID   = 1'b0;
    // Dummy cycle figures; SPI tables hold two bits per latency code
    localparam logic [7:0] SPI_ARG_TABLE = 8'h94;
    localparam logic [7:0] SPI_REG_TABLE = 8'h90;
    localparam logic [5:0] OCT_BASE      = 6'h03;
    localparam logic [5:0] UID_DUMMY     = 6'h20;
    localparam logic [5:0] CRC_DUMMY     = 6'h08;
    localparam logic [7:0] OPC_SMALL_ERASE = 8'h20;
    // Bus responses
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        MODE_SPI  = 2'b00,
        MODE_OSDR = 2'b01,
        MODE_ODDR = 2'b10
    } sarl_mode_e;

    typedef enum logic [2:0] {
        CLS_OTHER  = 3'b000,
        CLS_ARG    = 3'b001,
        CLS_DYB    = 3'b010,
        CLS_PLB    = 3'b011,
        CLS_IDENT  = 3'b100,
        CLS_STATUS = 3'b101,
        CLS_UID    = 3'b110,
        CLS_CRC    = 3'b111
    } sarl_class_e;

    typedef struct packed {
        logic [7:0]  opcode;
        sarl_class_e cls;
        sarl_mode_e  mode;
        logic        vol_target;
    } sarl_cmd_s;

    typedef struct packed {
        logic [1:0] lat;
        logic       arch;
    } sarl_cfg_s;
endpackage : sarl_pkg

/* tb/sarl_host_model.sv */
`timescale 1ns/1ps
// Host controller stand-in: one command frame per call, answer sampled mid-cycle
module sarl_host_model (
    // Link clock
    input  wire logic                link_clk,
    // Command out
    output logic                     cmd_valid,
    output sarl_pkg::sarl_cmd_s      cmd,
    // Device answer
    input  wire logic                dummy_valid,
    input  wire logic [5:0]          dummy_cycles,
    input  wire logic                erase_start
);
    // Idle values at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // Link rate of 33 MHz stays inside every latency code rating and the SDR limit
    task automatic send(input sarl_pkg::sarl_cmd_s c, output logic dv, output logic [5:0] dc, output logic es);
        @(posedge link_clk);
        cmd_valid <= 1'b1;
        cmd       <= c;
        @(posedge link_clk);
        cmd_valid <= 1'b0;
        cmd       <= ~c; // Released lines never keep the last value
        @(negedge link_clk);
        dv = dummy_valid;
        dc = dummy_cycles;
        es = erase_start;
    endtask : send
endmodule : sarl_host_model

/* tb/sarl_top_tb.sv */
`timescale 1ns/1ps
// Register bus tasks plus link command sweeps through the host model
module sarl_top_tb;
    localparam logic [5:0] NV_DUMMY = 6'h0A;
    // Bus and link signals
    logic                aclk;
    logic                aresetn;
    logic [7:0]          awaddr;
    logic [7:0]          araddr;
    logic [31:0]         wdata;
    logic [31:0]         rdata;
    logic [3:0]          wstrb;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready;
    logic                low_en, high_en, link_clk, cmd_valid, dummy_valid, erase_start;
    logic [5:0]          dummy_cycles;
    sarl_pkg::sarl_cmd_s cmd;
    int                  n_fail;
    int                  total_checks;

    // 10 MHz bus clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Link clock runs free since the config crossing needs its edges; phase unrelated to aclk
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    sarl_top #(.NV_ARG_DUMMY(NV_DUMMY)) u_sarl_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .small_sector_low_en(low_en),
        .small_sector_high_en(high_en), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .dummy_valid(dummy_valid), .dummy_cycles(dummy_cycles), .erase_start(erase_start)
    );
    sarl_host_model u_sarl_host_model (
        .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd), .dummy_valid(dummy_valid),
        .dummy_cycles(dummy_cycles), .erase_start(erase_start)
    );

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                done = 1'b1;
                chk({30'h0, bresp}, {30'h0, er}, "write response");
            end
        end
    endtask : wr

    // Read: address held until taken, rready held until rvalid
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                done = 1'b1;
                chk(rdata, ed, "read data");
                chk({30'h0, rresp}, {30'h0, er}, "read response");
            end
        end
    endtask : rd

    // Expected dummy count per class, mode and latency code
    function automatic logic [5:0] exp_dummy(input logic [2:0] cls, input logic [1:0] mode,
                                             input logic [1:0] code, input logic vol);
        if (cls == 3'h0) return 6'h00;
        if (cls == 3'h6) return 6'h20;
        if (cls == 3'h7) return 6'h08;
        if (cls == 3'h1 && !vol) return NV_DUMMY;
        if (mode != 2'h0) return 6'h03 + {4'h0, code};
        if (cls <= 3'h2) return (code == 2'h0) ? 6'h00 : ((code == 2'h3) ? 6'h02 : 6'h01);
        return code[1] ? {4'h0, code[0], ~code[0]} : 6'h00;
    endfunction : exp_dummy

    // Every class in every mode, plus a nonvolatile argument read
    task automatic link_sweep(input logic [1:0] code);
        sarl_pkg::sarl_cmd_s c;
        logic                dv, es;
        logic [5:0]          dc;
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 9; k++) begin
                c.opcode     = 8'h05;
                c.cls        = sarl_pkg::sarl_class_e'((k == 8) ? 3'h1 : k[2:0]);
                c.mode       = sarl_pkg::sarl_mode_e'(m[1:0]);
                c.vol_target = (k != 8);
                u_sarl_host_model.send(c, dv, dc, es);
                chk({26'h0, dc}, {26'h0, exp_dummy(c.cls, c.mode, code, c.vol_target)}, "dummies");
                chk({31'h0, dv}, {31'h0, (c.cls != sarl_pkg::CLS_OTHER)}, "dummy valid");
                chk({31'h0, es}, 32'h0, "stray erase");
            end
        end
    endtask : link_sweep

    // Small-sector erase command, then room for the status crossing
    task automatic erase_probe(input logic exp_es);
        sarl_pkg::sarl_cmd_s c;
        logic                dv, es;
        logic [5:0]          dc;
        c = '{opcode: sarl_pkg::OPC_SMALL_ERASE, cls: sarl_pkg::CLS_OTHER, mode: sarl_pkg::MODE_SPI, vol_target: 1'b0};
        u_sarl_host_model.send(c, dv, dc, es);
        chk({31'h0, es}, {31'h0, exp_es}, "erase pulse");
        repeat (6) @(posedge aclk);
    endtask : erase_probe

    // Verdict, the single exit
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Watchdog: the whole sequence needs well under 1000 bus cycles
    initial begin
        #2000000;
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    // Main sequence
    initial begin
        n_fail = 0;
        total_checks = 0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(sarl_pkg::ADDR_NV, 32'h0000_0000, sarl_pkg::RESP_OKAY);
        rd(sarl_pkg::ADDR_VOL, 32'h0000_0000, sarl_pkg::RESP_OKAY);
        rd(sarl_pkg::ADDR_STATUS, 32'h0000_0001, sarl_pkg::RESP_OKAY);
        chk({30'h0, low_en, high_en}, 32'h0000_0001, "default map");
        // Nonvolatile copy is writable, volatile arch bit is not; reserved bits kept zero
        wr(sarl_pkg::ADDR_NV, 32'h0000_00C8, sarl_pkg::RESP_OKAY);
        rd(sarl_pkg::ADDR_NV, 32'h0000_00C8, sarl_pkg::RESP_OKAY);
        // Low byte strobe off: write is answered but must not land
        wstrb <= 4'hE;
        wr(sarl_pkg::ADDR_NV, 32'h0000_0040, sarl_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        rd(sarl_pkg::ADDR_NV, 32'h0000_00C8, sarl_pkg::RESP_OKAY);
        wr(sarl_pkg::ADDR_VOL, 32'h0000_0008, sarl_pkg::RESP_OKAY);
        rd(sarl_pkg::ADDR_VOL, 32'h0000_0000, sarl_pkg::RESP_OKAY);
        wr(8'h18, 32'h0000_00FF, sarl_pkg::RESP_SLVERR);
        rd(8'h14, 32'h0000_0000, sarl_pkg::RESP_SLVERR);
        // Each latency code through the volatile copy, after the crossing settles
        for (int c = 0; c < 4; c++) begin
            wr(sarl_pkg::ADDR_VOL, {24'h0, c[1:0], 6'h00}, sarl_pkg::RESP_OKAY);
            repeat (6) @(posedge aclk);
            link_sweep(c[1:0]);
        end
        // Reload uniform layout from the nonvolatile copy
        wr(sarl_pkg::ADDR_CTRL, 32'h0000_0001, sarl_pkg::RESP_OKAY);
        rd(sarl_pkg::ADDR_VOL, 32'h0000_00C8, sarl_pkg::RESP_OKAY);
        repeat (6) @(posedge aclk);
        rd(sarl_pkg::ADDR_STATUS, 32'h0000_0000, sarl_pkg::RESP_OKAY);
        chk({30'h0, low_en, high_en}, 32'h0000_0000, "uniform map");
        erase_probe(1'b0);
        rd(sarl_pkg::ADDR_STATUS, 32'h0000_0002, sarl_pkg::RESP_OKAY);
        wr(sarl_pkg::ADDR_STATUS, 32'h0000_0002, sarl_pkg::RESP_OKAY);
        rd(sarl_pkg::ADDR_STATUS, 32'h0000_0000, sarl_pkg::RESP_OKAY);
        // Back to hybrid, split then bottom placement
        wr(sarl_pkg::ADDR_NV, 32'h0000_0000, sarl_pkg::RESP_OKAY);
        wr(sarl_pkg::ADDR_CTRL, 32'h0000_0001, sarl_pkg::RESP_OKAY);
        wr(sarl_pkg::ADDR_SECTOR, 32'h0000_0001, sarl_pkg::RESP_OKAY);
        @(posedge aclk);
        chk({30'h0, low_en, high_en}, 32'h0000_0003, "split map");
        wr(sarl_pkg::ADDR_SECTOR, 32'h0000_0002, sarl_pkg::RESP_OKAY);
        @(posedge aclk);
        chk({30'h0, low_en, high_en}, 32'h0000_0002, "low map");
        repeat (6) @(posedge aclk);
        erase_probe(1'b1);
        rd(sarl_pkg::ADDR_STATUS, 32'h0000_0005, sarl_pkg::RESP_OKAY);
        wr(sarl_pkg::ADDR_STATUS, 32'h0000_0004, sarl_pkg::RESP_OKAY);
        rd(sarl_pkg::ADDR_STATUS, 32'h0000_0001, sarl_pkg::RESP_OKAY);
        wrap_up();
    end
endmodule : sarl_top_tb
